// ---- core_regs_pkg.sv ----
// constants, encodings and decode functions for the banked register file
package core_regs_pkg;

	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int XLEN = 32;
	localparam int NUM_PHYS_GPR = 30;
	localparam int NUM_SAVED = 5;
	localparam int APB_AW = 12;

	// ----------------------------------------------------------------
	// mode encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;

	// ----------------------------------------------------------------
	// status word fields
	// ----------------------------------------------------------------
	localparam int PSR_FLAG_LSB = 28;
	localparam int PSR_IRQ_DIS = 7;
	localparam int PSR_FIQ_DIS = 6;
	localparam int PSR_MODE_LSB = 0;
	localparam logic [31:0] PSR_CTRL_MASK = 32'h0fffffff;
	localparam logic [31:0] PSR_FLAG_MASK = 32'hf0000000;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CURRENT_STATUS_WORD_RST = 32'h000000d3;
	localparam logic [31:0] PC_RST = 32'h00000000;

	// ----------------------------------------------------------------
	// physical bank bases
	// ----------------------------------------------------------------
	localparam logic [4:0] BASE_FIQ = 5'h0f;
	localparam logic [4:0] BASE_IRQ = 5'h16;
	localparam logic [4:0] BASE_SVC = 5'h18;
	localparam logic [4:0] BASE_ABT = 5'h1a;
	localparam logic [4:0] BASE_UND = 5'h1c;
	localparam logic [3:0] REG_LINK = 4'he;
	localparam logic [3:0] REG_PC = 4'hf;
	localparam logic [31:0] PC_ALIGN_MASK = 32'hfffffffc;
	localparam logic [31:0] ADDR26_MASK = 32'h03ffffff;

	// ----------------------------------------------------------------
	// configuration pin bit positions
	// ----------------------------------------------------------------
	localparam int CFG_ENDIAN = 0;
	localparam int CFG_PROGRAM_SPACE_32 = 1;
	localparam int CFG_DATA_SPACE_32 = 2;

	// ----------------------------------------------------------------
	// apb register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_DBG_SEL = 12'h008;
	localparam logic [11:0] OFS_DBG_DATA = 12'h00c;
	localparam logic [11:0] OFS_SAVED = 12'h010;

	function automatic logic mode_legal(input logic [4:0] m);
		return (m == MODE_USR) || (m == MODE_FIQ) || (m == MODE_IRQ) ||
			(m == MODE_SVC) || (m == MODE_ABT) || (m == MODE_UND);
	endfunction

	// saved word slot of a privileged mode
	function automatic logic [2:0] saved_slot(input logic [4:0] m);
		case (m)
			MODE_FIQ: return 3'h0;
			MODE_IRQ: return 3'h1;
			MODE_SVC: return 3'h2;
			MODE_ABT: return 3'h3;
			default: return 3'h4;
		endcase
	endfunction

	// visible register number to physical slot, by mode
	function automatic logic [4:0] phys_idx(input logic [4:0] m, input logic [3:0] r);
		logic [4:0] base;
		logic banked;
		base = 5'h00;
		banked = 1'b0;
		case (m)
			MODE_FIQ: begin
				base = BASE_FIQ - 5'h08;
				banked = (r >= 4'h8);
			end
			MODE_IRQ: begin
				base = BASE_IRQ - 5'h0d;
				banked = (r >= 4'hd);
			end
			MODE_SVC: begin
				base = BASE_SVC - 5'h0d;
				banked = (r >= 4'hd);
			end
			MODE_ABT: begin
				base = BASE_ABT - 5'h0d;
				banked = (r >= 4'hd);
			end
			MODE_UND: begin
				base = BASE_UND - 5'h0d;
				banked = (r >= 4'hd);
			end
			default: begin
				base = 5'h00;
				banked = 1'b0;
			end
		endcase
		return banked ? 5'(base + {1'b0, r}) : {1'b0, r};
	endfunction

	// condition test over n z c v
	function automatic logic cond_pass(input logic [3:0] cc, input logic [3:0] f);
		logic n, z, c, v, r;
		n = f[3];
		z = f[2];
		c = f[1];
		v = f[0];
		case (cc[3:1])
			3'h0: r = z;
			3'h1: r = c;
			3'h2: r = n;
			3'h3: r = v;
			3'h4: r = c & ~z;
			3'h5: r = (n == v);
			3'h6: r = ~z & (n == v);
			default: r = 1'b1;
		endcase
		return (cc == 4'hf) ? 1'b0 : (cc == 4'he) ? 1'b1 : (r ^ cc[0]);
	endfunction

endpackage

// ---- gpr_mem.sv ----
// physical general register storage, one write and three registered reads
module gpr_mem
	import core_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write port
	input wire logic wrEn,
	input wire logic [4:0] wrAddr,
	input wire logic [31:0] wrData,
	// read ports
	input wire logic [4:0] rdAddrA,
	input wire logic [4:0] rdAddrB,
	input wire logic [4:0] rdAddrC,
	output logic [31:0] rdDataA,
	output logic [31:0] rdDataB,
	output logic [31:0] rdDataC
);
	import core_regs_pkg::*;

	typedef struct packed {
		logic [NUM_PHYS_GPR-1:0][31:0] word;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
	} mem_t;

	mem_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		// read before write: old word comes out on a same-cycle hit
		s_d.a = s_q.word[rdAddrA];
		s_d.b = s_q.word[rdAddrB];
		s_d.c = s_q.word[rdAddrC];
		if (wrEn) begin
			s_d.word[wrAddr] = wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdDataA = s_q.a;
	assign rdDataB = s_q.b;
	assign rdDataC = s_q.c;
endmodule

// ---- lane_steer.sv ----
// byte lane placement for stores and loads by endian setting
module lane_steer
	import core_regs_pkg::*;
(
	// access description
	input wire logic endianSel,
	input wire logic byteMode,
	input wire logic [1:0] addrLow,
	// data in and out
	input wire logic [31:0] storeData,
	input wire logic [31:0] busRdData,
	output logic [31:0] busWrData,
	output logic [3:0] byteEn,
	output logic [31:0] loadData
);
	import core_regs_pkg::*;

	logic [1:0] lane;
	logic [7:0] pick;

	// big endian puts byte 0 on the top lane
	assign lane = endianSel ? ~addrLow : addrLow;
	assign pick = busRdData[8*lane +: 8];

	// stores replicate a byte on every lane, strobe picks one
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			assign byteEn[i] = ~byteMode | (lane == 2'(i));
			assign busWrData[8*i +: 8] = byteMode ? storeData[7:0] : storeData[8*i +: 8];
		end
	endgenerate

	// words are aligned, so the low address bits do not move a word
	assign loadData = byteMode ? {24'h000000, pick} : busRdData;
endmodule

// ---- banked_regfile.sv ----
// banked register file with program counter, status words and apb view
//
// Added by the designer: register access over APB and the placing of the registers.
module banked_regfile
	import core_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration pins
	input wire logic endianSelect,
	input wire logic programSpace32,
	input wire logic dataSpace32,
	// interrupt request pins, active high
	input wire logic irqRequest,
	input wire logic fiqRequest,
	// register reads
	input wire logic [3:0] rdIdxA,
	input wire logic [3:0] rdIdxB,
	output logic [31:0] rdDataA,
	output logic [31:0] rdDataB,
	// register write and branch-link
	input wire logic wrEn,
	input wire logic [3:0] wrIdx,
	input wire logic [31:0] wrData,
	input wire logic linkEn,
	// program counter
	input wire logic pcWrEn,
	input wire logic [31:0] pcWrData,
	output logic [31:0] pcOut,
	// flags and condition test
	input wire logic flagEn,
	input wire logic [3:0] flagNzcv,
	input wire logic [3:0] condCode,
	output logic condPass,
	// status word write, restore, exception entry
	input wire logic psrWrEn,
	input wire logic psrWrSaved,
	input wire logic psrWrFlags,
	input wire logic psrWrCtrl,
	input wire logic [31:0] psrWrData,
	input wire logic restoreEn,
	input wire logic excEn,
	input wire logic [4:0] excMode,
	output logic [31:0] cpsrOut,
	output logic [31:0] spsrOut,
	output logic privileged,
	output logic lockedUp,
	// interrupt acceptance
	output logic irqTake,
	output logic fiqTake,
	// memory data lanes and address
	input wire logic memByte,
	input wire logic [31:0] memAddr,
	input wire logic memFetch,
	input wire logic [31:0] storeData,
	input wire logic [31:0] busRdData,
	output logic [31:0] busWrData,
	output logic [3:0] busByteEn,
	output logic [31:0] loadData,
	output logic [31:0] busAddr,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import core_regs_pkg::*;

	typedef struct packed {
		logic [2:0] cfgMeta;
		logic [2:0] cfgSync;
		logic [1:0] intMeta;
		logic [1:0] intSync;
		logic [31:0] pc;
		logic [31:0] current_status_word;
		logic [NUM_SAVED-1:0][31:0] saved;
		logic locked;
		logic [3:0] dbgSel;
		logic selPcA;
		logic selPcB;
		logic [31:0] pcSnapA;
		logic [31:0] pcSnapB;
		logic [31:0] rdA;
		logic [31:0] rdB;
		logic [31:0] spsrView;
		logic condPass;
		logic irqTake;
		logic fiqTake;
		logic priv;
		logic [31:0] busWr;
		logic [3:0] byteEn;
		logic [31:0] ldData;
		logic [31:0] addr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

	state_t s_q, s_d;

	logic [4:0] mode;
	logic isPriv;
	logic [2:0] slot;
	logic [31:0] pcRead;
	logic memWrEn;
	logic [4:0] memWrAddr;
	logic [31:0] memWrData;
	logic [31:0] memA, memB, memC;
	logic [31:0] laneWr, laneLd;
	logic [3:0] laneEn;

	// ----------------------------------------------------------------
	// bank selection
	// ----------------------------------------------------------------
	// bank from current mode
	assign mode = s_q.current_status_word[PSR_MODE_LSB +: 5];
	assign isPriv = (mode != MODE_USR);
	assign slot = saved_slot(mode);
	assign pcRead = s_q.pc & PC_ALIGN_MASK;

	// 30 banked words here, pc and six status words below
	gpr_mem u_mem (
		.clk(clk),
		.sys_rst(sys_rst),
		.wrEn(memWrEn),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		// fiq maps r8 to r14 privately
		.rdAddrA(phys_idx(mode, rdIdxA)),
		.rdAddrB(phys_idx(mode, rdIdxB)),
		.rdAddrC(phys_idx(mode, s_q.dbgSel)),
		.rdDataA(memA),
		.rdDataB(memB),
		.rdDataC(memC)
	);

	// only the load/store path sees endian
	lane_steer u_lane (
		.endianSel(s_q.cfgSync[CFG_ENDIAN]),
		.byteMode(memByte),
		.addrLow(memAddr[1:0]),
		.storeData(storeData),
		.busRdData(busRdData),
		.busWrData(laneWr),
		.byteEn(laneEn),
		.loadData(laneLd)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] nextPsr;
		logic [2:0] excSlot;
		logic apbAccess;
		nextPsr = '0;
		excSlot = saved_slot(excMode);
		apbAccess = psel & penable & ~s_q.pready;
		s_d = s_q;
		memWrEn = 1'b0;
		memWrAddr = 5'h00;
		memWrData = '0;

		// pins from outside: two flops before use
		// live config changes tracked
		s_d.cfgMeta = {dataSpace32, programSpace32, endianSelect};
		s_d.cfgSync = s_q.cfgMeta;
		s_d.intMeta = {fiqRequest, irqRequest};
		s_d.intSync = s_q.intMeta;

		// locked core ignores every register, pc and status change until reset
		if (!s_q.locked) begin
			if (excEn) begin
				// save pc in link, status in saved word
				memWrEn = 1'b1;
				memWrAddr = phys_idx(excMode, REG_LINK);
				memWrData = pcRead;
				// entered mode's saved word gets old status
				s_d.saved[excSlot] = s_q.current_status_word;
				s_d.current_status_word[PSR_MODE_LSB +: 5] = excMode;
				s_d.current_status_word[PSR_IRQ_DIS] = 1'b1;
				if (excMode == MODE_FIQ) begin
					s_d.current_status_word[PSR_FIQ_DIS] = 1'b1;
				end
				s_d.locked = ~mode_legal(excMode);
			end else begin
				if (linkEn) begin
					memWrEn = 1'b1;
					memWrAddr = phys_idx(mode, REG_LINK);
					memWrData = pcRead;
				end else if (wrEn && wrIdx != REG_PC) begin
					memWrEn = 1'b1;
					memWrAddr = phys_idx(mode, wrIdx);
					memWrData = wrData;
				end
				if (pcWrEn) begin
					s_d.pc = pcWrData & PC_ALIGN_MASK;
				end else if (wrEn && wrIdx == REG_PC && !linkEn) begin
					s_d.pc = wrData & PC_ALIGN_MASK;
				end
				if (flagEn) begin
					s_d.current_status_word[PSR_FLAG_LSB +: 4] = flagNzcv;
				end
				if (restoreEn && isPriv) begin
					s_d.current_status_word = s_q.saved[slot];
				end else if (psrWrEn && (!psrWrSaved || isPriv)) begin
					nextPsr = psrWrSaved ? s_q.saved[slot] : s_q.current_status_word;
					if (psrWrFlags) begin
						nextPsr = (nextPsr & ~PSR_FLAG_MASK) | (psrWrData & PSR_FLAG_MASK);
					end
					if (psrWrCtrl && isPriv) begin
						nextPsr = (nextPsr & ~PSR_CTRL_MASK) | (psrWrData & PSR_CTRL_MASK);
					end
					if (psrWrSaved) begin
						s_d.saved[slot] = nextPsr;
					end else begin
						s_d.current_status_word = nextPsr;
					end
				end
				// undefined mode value locks the core
				if (!mode_legal(s_d.current_status_word[PSR_MODE_LSB +: 5])) begin
					s_d.locked = 1'b1;
				end
			end
		end

		// ------------------------------------------------------------
		// read ports: memory flop, then pc substitution flop
		// ------------------------------------------------------------
		s_d.selPcA = (rdIdxA == REG_PC);
		s_d.selPcB = (rdIdxB == REG_PC);
		s_d.pcSnapA = pcRead;
		s_d.pcSnapB = pcRead;
		s_d.rdA = s_q.selPcA ? s_q.pcSnapA : memA;
		s_d.rdB = s_q.selPcB ? s_q.pcSnapB : memB;

		// user mode has no saved word to show
		s_d.spsrView = isPriv ? s_q.saved[slot] : '0;
		s_d.priv = isPriv;
		s_d.condPass = cond_pass(condCode, s_q.current_status_word[PSR_FLAG_LSB +: 4]);

		s_d.irqTake = s_q.intSync[0] & ~s_q.current_status_word[PSR_IRQ_DIS] & ~s_q.locked;
		s_d.fiqTake = s_q.intSync[1] & ~s_q.current_status_word[PSR_FIQ_DIS] & ~s_q.locked;

		// ------------------------------------------------------------
		// memory lanes and address space
		// ------------------------------------------------------------
		// byte lanes via steering, by endian setting
		s_d.busWr = laneWr;
		s_d.byteEn = laneEn;
		s_d.ldData = laneLd;
		// 26-bit space drops the top six address lines
		if (memFetch ? s_q.cfgSync[CFG_PROGRAM_SPACE_32] : s_q.cfgSync[CFG_DATA_SPACE_32]) begin
			s_d.addr = memAddr;
		end else begin
			s_d.addr = memAddr & ADDR26_MASK;
		end

		// ------------------------------------------------------------
		// apb slave: one wait state, answer on second access cycle
		// ------------------------------------------------------------
		s_d.pready = apbAccess;
		s_d.pslverr = 1'b0;
		if (apbAccess) begin
			s_d.prdata = '0;
			case (paddr)
				OFS_STATUS: begin
					s_d.prdata = s_q.current_status_word;
				end
				OFS_CONFIG: begin
					s_d.prdata = {28'h0000000, s_q.locked, s_q.cfgSync};
				end
				OFS_DBG_SEL: begin
					s_d.prdata = {28'h0000000, s_q.dbgSel};
					if (pwrite) begin
						s_d.dbgSel = pwdata[3:0];
					end
				end
				OFS_DBG_DATA: begin
					s_d.prdata = (s_q.dbgSel == REG_PC) ? pcRead : memC;
				end
				OFS_SAVED: begin
					s_d.prdata = s_q.spsrView;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
			if (pwrite && paddr != OFS_DBG_SEL) begin
				s_d.pslverr = 1'b1;
			end
		end
	end

	// all state changes on the clock edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.current_status_word <= CURRENT_STATUS_WORD_RST;
			s_q.pc <= PC_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdDataA = s_q.rdA;
	assign rdDataB = s_q.rdB;
	assign pcOut = s_q.pc;
	assign condPass = s_q.condPass;
	assign cpsrOut = s_q.current_status_word;
	assign spsrOut = s_q.spsrView;
	assign privileged = s_q.priv;
	assign lockedUp = s_q.locked;
	assign irqTake = s_q.irqTake;
	assign fiqTake = s_q.fiqTake;
	assign busWrData = s_q.busWr;
	assign busByteEn = s_q.byteEn;
	assign loadData = s_q.ldData;
	assign busAddr = s_q.addr;
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
endmodule

// ---- banked_regfile_checker.sv ----
// concurrent checks on the banked register file ports
module banked_regfile_checker
	import core_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// memory lanes
	input wire logic endianSelect,
	input wire logic memByte,
	input wire logic [31:0] memAddr,
	input wire logic [3:0] busByteEn,
	// program counter
	input wire logic pcWrEn,
	input wire logic [31:0] pcWrData,
	input wire logic [31:0] pcOut,
	// status words
	input wire logic psrWrEn,
	input wire logic psrWrSaved,
	input wire logic psrWrCtrl,
	input wire logic [31:0] psrWrData,
	input wire logic restoreEn,
	input wire logic excEn,
	input wire logic [4:0] excMode,
	input wire logic [31:0] cpsrOut,
	input wire logic [31:0] spsrOut,
	input wire logic privileged,
	input wire logic lockedUp,
	input wire logic irqTake,
	input wire logic fiqTake
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ------
	// history of pins and state
	// ------
	logic [3:0] endHist_q;
	logic [1:0] addrLow_q;
	logic [1:0] maskPast_q;
	logic [4:0] modePast_q;
	// pin history covers the two-flop synchroniser delay
	always_ff @(posedge clk) begin
		endHist_q <= {endHist_q[2:0], endianSelect};
		addrLow_q <= memAddr[1:0];
		maskPast_q <= cpsrOut[7:6];
		modePast_q <= cpsrOut[4:0];
	end
	// ------
	// properties
	// ------
	property p_laneLittle;
		memByte && endHist_q == 4'h0 && !endianSelect |=> busByteEn == (4'h1 << addrLow_q);
	endproperty
	a_laneLittle: assert property (p_laneLittle) else $error("little endian byte lane wrong");
	property p_laneBig;
		memByte && endHist_q == 4'hf && endianSelect |=> busByteEn == (4'h8 >> addrLow_q);
	endproperty
	a_laneBig: assert property (p_laneBig) else $error("big endian byte lane wrong");
	property p_fiqEntry;
		excEn && !lockedUp && excMode == MODE_FIQ |=> cpsrOut[4:0] == MODE_FIQ && cpsrOut[7:6] == 2'b11;
	endproperty
	a_fiqEntry: assert property (p_fiqEntry) else $error("fast entry mode or masks wrong");
	property p_excSave;
		excEn && !lockedUp |=> ##1 spsrOut == $past(cpsrOut, 2);
	endproperty
	a_excSave: assert property (p_excSave) else $error("saved word not old status");
	property p_pcWrite;
		pcWrEn && !excEn && !lockedUp |=> pcOut == ($past(pcWrData) & PC_ALIGN_MASK);
	endproperty
	a_pcWrite: assert property (p_pcWrite) else $error("pc write value wrong");
	property p_privileged;
		!$past(sys_rst) |-> privileged == (modePast_q != MODE_USR);
	endproperty
	a_privileged: assert property (p_privileged) else $error("privileged flag wrong");
	property p_maskTake;
		(maskPast_q & cpsrOut[7:6] & {irqTake, fiqTake}) == 2'b00;
	endproperty
	a_maskTake: assert property (p_maskTake) else $error("masked interrupt taken");
	property p_lockStick;
		lockedUp |=> lockedUp;
	endproperty
	a_lockStick: assert property (p_lockStick) else $error("lock cleared without reset");
	property p_lockOn;
		psrWrEn && psrWrCtrl && !psrWrSaved && !excEn && !restoreEn && !lockedUp && cpsrOut[4:0] != MODE_USR
			&& psrWrData[4:0] == 5'h1f |-> ##[1:2] lockedUp;
	endproperty
	a_lockOn: assert property (p_lockOn) else $error("illegal mode did not lock");
	property p_userCtrl;
		psrWrEn && psrWrCtrl && !psrWrSaved && !excEn && !restoreEn && cpsrOut[4:0] == MODE_USR
			|=> ((cpsrOut ^ $past(cpsrOut)) & PSR_CTRL_MASK) == 32'h0;
	endproperty
	a_userCtrl: assert property (p_userCtrl) else $error("control bits changed in user mode");
endmodule

// ---- mem_model.sv ----
// far-side memory: word pattern by word address, prompt or one cycle late
module mem_model (
	// clock and pace
	input wire logic clk,
	input wire logic slowMem,
	// bus
	input wire logic [31:0] busAddr,
	output logic [31:0] busRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] fast;
	logic [31:0] word_q;
	assign fast = 32'h44332211 ^ {24'h0, busAddr[9:2]};
	always_ff @(posedge clk) begin
		word_q <= fast;
	end
	assign busRdData = slowMem ? word_q : fast;
endmodule

// ---- tb_banked_register_file_psr.sv ----
// self-checking bench for the banked register file
module tb_banked_register_file_psr;
	timeunit 1ns;
	timeprecision 1ps;
	import core_regs_pkg::*;
	logic clk, sys_rst, endianSelect, programSpace32, dataSpace32, irqRequest, fiqRequest, psrWrSaved;
	logic psrWrFlags, psrWrCtrl, condPass, privileged, lockedUp, irqTake, fiqTake, memByte, memFetch;
	logic psel, penable, pwrite, pready, pslverr, slowMem, err;
	logic [6:0] ctl;
	logic [3:0] rdIdxA, rdIdxB, wrIdx, flagNzcv, condCode, busByteEn;
	logic [4:0] excMode;
	logic [11:0] paddr;
	logic [31:0] rdDataA, rdDataB, wrData, pcWrData, pcOut, psrWrData, cpsrOut, spsrOut, memAddr, storeData;
	logic [31:0] busRdData, busWrData, loadData, busAddr, pwdata, prdata, rv, w;
	logic [4:0] modes [3] = '{MODE_IRQ, MODE_ABT, MODE_UND};
	logic [3:0] fl [2] = '{4'h6, 4'h9};
	int num_errors = 0;
	int tests_run = 0;
	localparam logic [6:0] WR = 7'h01, LINK = 7'h02, PCW = 7'h04, FLG = 7'h08, PSRW = 7'h10, RESTORE = 7'h20;
	localparam logic [6:0] EXC = 7'h40;
	banked_regfile u_dut (.clk, .sys_rst, .endianSelect, .programSpace32, .dataSpace32, .irqRequest, .fiqRequest,
		.rdIdxA, .rdIdxB, .rdDataA, .rdDataB, .wrEn(ctl[0]), .wrIdx, .wrData, .linkEn(ctl[1]), .pcWrEn(ctl[2]),
		.pcWrData, .pcOut, .flagEn(ctl[3]), .flagNzcv, .condCode, .condPass, .psrWrEn(ctl[4]), .psrWrSaved,
		.psrWrFlags, .psrWrCtrl, .psrWrData, .restoreEn(ctl[5]), .excEn(ctl[6]), .excMode, .cpsrOut, .spsrOut,
		.privileged, .lockedUp, .irqTake, .fiqTake, .memByte, .memAddr, .memFetch, .storeData, .busRdData,
		.busWrData, .busByteEn, .loadData, .busAddr, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	mem_model u_mem (.clk, .slowMem, .busAddr, .busRdData);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ------
	// helpers
	// ------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic [6:0] c);
		@(posedge clk);
		ctl <= c;
		@(posedge clk);
		ctl <= '0;
	endtask
	task automatic rd(input logic [3:0] i, input logic [31:0] exp);
		@(posedge clk);
		rdIdxA <= i;
		rdIdxB <= i;
		tick(3);
		check("rdDataA", rdDataA, exp);
		check("rdDataB", rdDataB, exp);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// look just after each edge so the next edge is the one that samples pready high
		#1;
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		r = prdata;
		e = pslverr;
		if (n >= 50) num_errors++;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic cexp(input logic [3:0] cc, input logic [3:0] f);
		logic [7:0] b;
		b = {1'b1, ~f[2] & (f[3] == f[0]), f[3] == f[0], f[1] & ~f[2], f[0], f[3], f[1], f[2]};
		return (cc == 4'hf) ? 1'b0 : b[cc[3:1]] ^ cc[0];
	endfunction
	function automatic logic [31:0] memWord(input logic [31:0] a);
		return 32'h44332211 ^ {24'h0, a[9:2]};
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200us;
		num_errors++;
		complete_run();
	end
	// ------
	// main sequence
	// ------
	initial begin
		{sys_rst, programSpace32, dataSpace32} = 3'b111;
		{endianSelect, irqRequest, fiqRequest, psrWrSaved, psrWrFlags, psrWrCtrl, memByte, memFetch} = '0;
		{psel, penable, pwrite, slowMem, ctl} = '0;
		{rdIdxA, rdIdxB, wrIdx, flagNzcv, condCode, excMode} = '0;
		{paddr, wrData, pcWrData, psrWrData, memAddr, storeData, pwdata} = '0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		tick(1);
		check("cpsrOut", cpsrOut, CURRENT_STATUS_WORD_RST);
		apb(1'b0, 12'h020, 32'h0, rv, err);
		check("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h0, rv, err);
		check("ro write", {31'h0, err}, 32'h1);
		apb(1'b0, OFS_CONFIG, 32'h0, rv, err);
		check("config", rv & 32'hf, 32'h6);
		for (int i = 0; i < 15; i++) begin
			wrIdx <= 4'(i);
			wrData <= 32'h100 + i;
			pulse(WR);
		end
		pcWrData <= 32'h1237;
		pulse(PCW);
		rd(4'hf, 32'h1234);
		pulse(LINK);
		rd(4'he, 32'h1234);
		pcWrData <= 32'h567b;
		pulse(PCW);
		excMode <= MODE_FIQ;
		pulse(EXC);
		tick(2);
		check("fiq current_status_word", cpsrOut & 32'hdf, 32'hd1);
		check("fiq saved", spsrOut, CURRENT_STATUS_WORD_RST);
		rd(4'he, 32'h5678);
		rd(4'h7, 32'h107);
		for (int i = 8; i < 15; i++) begin
			wrIdx <= 4'(i);
			wrData <= 32'h200 + i;
			pulse(WR);
		end
		pulse(RESTORE);
		tick(1);
		check("restored", cpsrOut, CURRENT_STATUS_WORD_RST);
		for (int i = 8; i < 15; i++) rd(4'(i), (i == 14) ? 32'h1234 : 32'h100 + i);
		foreach (modes[k]) begin
			excMode <= modes[k];
			pulse(EXC);
			tick(2);
			check("mode", {27'h0, cpsrOut[4:0]}, {27'h0, modes[k]});
			check("saved", spsrOut, CURRENT_STATUS_WORD_RST);
			rd(4'hc, 32'h10c);
			wrIdx <= 4'hd;
			wrData <= 32'h300 + k;
			pulse(WR);
			rd(4'hd, 32'h300 + k);
			pulse(RESTORE);
			rd(4'hd, 32'h10d);
		end
		foreach (fl[j]) begin
			flagNzcv <= fl[j];
			pulse(FLG);
			tick(1);
			check("flags", cpsrOut >> 28, {28'h0, fl[j]});
			for (int c = 0; c < 16; c++) begin
				condCode <= 4'(c);
				tick(2);
				check("condPass", {31'h0, condPass}, {31'h0, cexp(4'(c), fl[j])});
			end
		end
		for (int e = 0; e < 2; e++) begin
			endianSelect <= e[0];
			for (int k = 0; k < 4; k++) begin
				memByte <= 1'b1;
				memAddr <= 32'h40 + k;
				storeData <= 32'hab;
				tick(4);
				w = memWord(32'h40) >> (8 * (e ? 3 - k : k));
				check("byteEn", {28'h0, busByteEn}, e ? 32'h8 >> k : 32'h1 << k);
				check("store", busWrData, 32'habababab);
				check("load", loadData, w & 32'hff);
			end
			rd(4'h5, 32'h105);
		end
		memByte <= 1'b0;
		slowMem <= 1'b1;
		memAddr <= 32'hfc000083;
		tick(4);
		check("word en", {28'h0, busByteEn}, 32'hf);
		check("word load", loadData, memWord(32'h80));
		dataSpace32 <= 1'b0;
		tick(4);
		check("addr26", busAddr, 32'h00000083);
		dataSpace32 <= 1'b1;
		// control field written as 0x10: user mode, both interrupt masks cleared
		psrWrCtrl <= 1'b1;
		psrWrData <= 32'h00000010;
		pulse(PSRW);
		tick(2);
		check("user", {31'h0, privileged}, 32'h0);
		irqRequest <= 1'b1;
		fiqRequest <= 1'b1;
		tick(5);
		check("takes", {30'h0, irqTake, fiqTake}, 32'h3);
		psrWrFlags <= 1'b1;
		psrWrData <= 32'h500000d3;
		pulse(PSRW);
		tick(1);
		check("user write", cpsrOut, 32'h50000010);
		excMode <= MODE_FIQ;
		pulse(EXC);
		tick(3);
		check("masked", {30'h0, irqTake, fiqTake}, 32'h0);
		apb(1'b1, OFS_DBG_SEL, 32'h8, rv, err);
		tick(2);
		apb(1'b0, OFS_DBG_DATA, 32'h0, rv, err);
		check("dbg r8", rv, 32'h208);
		apb(1'b0, OFS_SAVED, 32'h0, rv, err);
		check("apb saved", rv, 32'h50000010);
		psrWrFlags <= 1'b0;
		psrWrData <= 32'h0000001f;
		pulse(PSRW);
		tick(2);
		check("locked", {31'h0, lockedUp}, 32'h1);
		pcWrData <= 32'h0;
		pulse(PCW);
		tick(1);
		check("frozen pc", pcOut, 32'h5678);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		tick(1);
		check("unlocked", {31'h0, lockedUp}, 32'h0);
		complete_run();
	end
endmodule

bind banked_regfile banked_regfile_checker u_chk (.clk, .sys_rst, .endianSelect, .memByte, .memAddr, .busByteEn,
	.pcWrEn, .pcWrData, .pcOut, .psrWrEn, .psrWrSaved, .psrWrCtrl, .psrWrData, .restoreEn, .excEn, .excMode,
	.cpsrOut, .spsrOut, .privileged, .lockedUp, .irqTake, .fiqTake);
